// ### logic/sta_pkg.sv
// Purpose: shared constants and types for the station table block
// Assumes: single core clock, synchronous reset
// Notes: register indices are word offsets on the plain register port
package sta_pkg;
   localparam int ROW_BITS = 10;
   localparam int ROWS = 1024;
   localparam int BUCKETS = 4;
   localparam int ENTRIES = 4096;
   localparam int ADDR_BITS = 48;
   localparam int VLAN_BITS = 13;
   localparam int DEST_BITS = 6;
   localparam int PORTS = 11;
   localparam int PORT_BITS = 4;
   localparam int CNT_BITS = 12;
   // register word offsets
   localparam logic [3:0] REG_KEY_LOW = 4'h0;
   localparam logic [3:0] REG_KEY_HIGH = 4'h1;
   localparam logic [3:0] REG_INDEX = 4'h2;
   localparam logic [3:0] REG_ACCESS = 4'h3;
   localparam logic [3:0] REG_OPTIONS = 4'h4;
   localparam logic [3:0] REG_PERIOD = 4'h5;
   localparam logic [3:0] REG_DEFAULTS = 4'h6;
   localparam logic [3:0] REG_DISCARD = 4'h7;
   localparam logic [3:0] REG_LIMIT_SEL = 4'h8;
   localparam logic [3:0] REG_LIMIT = 4'h9;
   localparam logic [3:0] REG_LEARN_CNT = 4'ha;
   // access register fields
   localparam int ACC_CMD_LSB = 0;
   localparam int ACC_TYPE_LSB = 4;
   localparam int ACC_AGED_BIT = 6;
   localparam int ACC_COPY_BIT = 7;
   localparam int ACC_DROP_BIT = 8;
   localparam int ACC_BYPASS_BIT = 9;
   localparam int ACC_VALID_BIT = 10;
   localparam int ACC_DEST_LSB = 16;
   // defaults register fields
   localparam int DEF_LEARN_EN_BIT = 0;
   localparam int DEF_COPY_BIT = 1;
   localparam int DEF_DROP_BIT = 2;
   localparam int DEF_BYPASS_BIT = 3;
   localparam logic [31:0] DEFAULTS_RESET = 32'h0000_0001;
   localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
   localparam logic [CNT_BITS-1:0] LIMIT_RESET = 12'hfff;
   localparam logic [1:0] TYPE_AGING = 2'h0;
   localparam logic [1:0] TYPE_LOCKED = 2'h1;
   localparam logic [1:0] TYPE_MC4 = 2'h2;
   localparam logic [1:0] TYPE_MC6 = 2'h3;
   localparam logic [2:0] CMD_IDLE = 3'h0;
   localparam logic [2:0] CMD_AGE = 3'h3;
   localparam logic [2:0] CMD_READ = 3'h4;
   localparam logic [2:0] CMD_WRITE = 3'h5;
   // one period tick is one microsecond of the 100 MHz core clock
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;

   typedef struct packed {
      logic valid;
      logic [ADDR_BITS-1:0] stationAddr;
      logic [VLAN_BITS-1:0] vlan;
      logic [DEST_BITS-1:0] destPtr;
      logic [1:0] entryType;
      logic aged;
      logic copyFlag;
      logic dropFlag;
      logic bypassFlag;
   } sta_entry_type;

   typedef struct packed {
      logic [ADDR_BITS-1:0] srcAddr;
      logic [ADDR_BITS-1:0] dstAddr;
      logic [VLAN_BITS-2:0] vlan;
      logic [PORT_BITS-1:0] port;
   } sta_req_type;

   typedef struct packed {
      logic srcHit;
      logic srcDrop;
      logic dstHit;
      logic [DEST_BITS-1:0] dstPtr;
      logic copyCpu;
      logic vlanBypass;
   } sta_resp_type;
endpackage

// ### logic/sta_station_table.sv
// Purpose: station table with hardware learning, station move and aging
// Assumes: lookups arrive as one-cycle requests while reqReady is high
// Notes: one lookup/learn at a time; answer two cycles after request
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module sta_station_table #(
   parameter int PERIOD_TICKS = sta_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic reqValid,
   input wire sta_pkg::sta_req_type reqData,
   output logic reqReady,
   output logic respValid,
   output sta_pkg::sta_resp_type respData
);
   if (PERIOD_TICKS < 1) begin
      $error("PERIOD_TICKS must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [sta_pkg::ROW_BITS-1:0] hashRow(
      input logic [sta_pkg::ADDR_BITS-1:0] a,
      input logic [sta_pkg::VLAN_BITS-1:0] v);
      logic [59:0] k;
      k = {a[47:0], v[11:0]};
      hashRow = k[9:0] ^ k[19:10] ^ k[29:20] ^ k[39:30] ^ k[49:40]
         ^ k[59:50] ^ {9'h000, v[12]};
   endfunction

   sta_pkg::sta_entry_type table_reg [sta_pkg::ENTRIES];
   logic [sta_pkg::CNT_BITS-1:0] limit_reg [sta_pkg::PORTS];
   logic [sta_pkg::CNT_BITS-1:0] learned_reg [sta_pkg::PORTS];

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOOK = 3'b001,
      ST_ANSWER = 3'b011,
      ST_SCAN = 3'b010,
      ST_CPU = 3'b110
   } sta_state_type;
   sta_state_type state_reg;

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] keyLow_reg, keyHigh_reg, index_reg, options_reg;
   logic [31:0] period_reg, defaults_reg, access_reg;
   logic [31:0] discard_reg;
   logic [3:0] limitSel_reg;
   sta_pkg::sta_req_type req_reg;
   logic [11:0] scanIdx_reg;
   logic [31:0] tickCnt_reg, periodCnt_reg;
   logic scanPend_reg;
   logic [31:0] regRdData_next;

   wire logic [2:0] cmdField = access_reg[2:0];
   wire logic cmdBusy = cmdField != sta_pkg::CMD_IDLE;
   wire logic [sta_pkg::ROW_BITS-1:0] srcRow =
      hashRow(req_reg.srcAddr, {1'b0, req_reg.vlan});
   wire logic [sta_pkg::ROW_BITS-1:0] dstRow =
      hashRow(req_reg.dstAddr, {1'b0, req_reg.vlan});
   wire logic [11:0] cpuIdx = {index_reg[9:0], index_reg[17:16]};
   wire logic learnEn = defaults_reg[sta_pkg::DEF_LEARN_EN_BIT];
   wire logic [3:0] logical_ingress_port = req_reg.port;
   wire logic portOk = 32'(logical_ingress_port) < sta_pkg::PORTS;

   // source and destination bucket match
   logic [3:0] srcMatch, dstMatch, freeMask;
   always_comb begin
      for (int b = 0; b < sta_pkg::BUCKETS; b++) begin
         sta_pkg::sta_entry_type s, d;
         s = table_reg[{srcRow, 2'(b)}];
         d = table_reg[{dstRow, 2'(b)}];
         srcMatch[b] = s.valid && s.stationAddr == req_reg.srcAddr
            && s.vlan == {1'b0, req_reg.vlan};
         dstMatch[b] = d.valid && d.stationAddr == req_reg.dstAddr
            && d.vlan == {1'b0, req_reg.vlan};
         freeMask[b] = !s.valid;
      end
   end

   function automatic logic [1:0] firstBit(input logic [3:0] m);
      firstBit = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
   endfunction

   wire logic [1:0] srcB = firstBit(srcMatch);
   wire logic [1:0] dstB = firstBit(dstMatch);
   wire logic [1:0] freeB = firstBit(freeMask);
   wire logic srcHit = |srcMatch;
   wire logic dstHit = |dstMatch;
   wire sta_pkg::sta_entry_type srcEnt = table_reg[{srcRow, srcB}];
   wire sta_pkg::sta_entry_type dstEnt = table_reg[{dstRow, dstB}];
   wire logic underLimit = portOk
      && learned_reg[logical_ingress_port] < limit_reg[logical_ingress_port];
   wire logic doLearn = learnEn && !srcHit && portOk && underLimit;
   wire logic noRoom = doLearn && !(|freeMask);

   sta_pkg::sta_entry_type learnEnt;
   always_comb begin
      learnEnt = '0;
      learnEnt.valid = 1'b1;
      learnEnt.stationAddr = req_reg.srcAddr;
      learnEnt.vlan = {1'b0, req_reg.vlan};
      learnEnt.entryType = sta_pkg::TYPE_AGING;
      learnEnt.destPtr = 6'(logical_ingress_port);
      learnEnt.copyFlag = defaults_reg[sta_pkg::DEF_COPY_BIT];
      learnEnt.dropFlag = defaults_reg[sta_pkg::DEF_DROP_BIT];
      learnEnt.bypassFlag = defaults_reg[sta_pkg::DEF_BYPASS_BIT];
   end

   // updated source entry on a hit
   sta_pkg::sta_entry_type hitEnt;
   always_comb begin
      hitEnt = srcEnt;
      if (srcEnt.entryType == sta_pkg::TYPE_AGING) begin
         hitEnt.aged = 1'b0;
         hitEnt.destPtr = 6'(logical_ingress_port);
      end else if (srcEnt.entryType == sta_pkg::TYPE_LOCKED) begin
         hitEnt.aged = 1'b0;
      end
   end

   // scan step result
   wire sta_pkg::sta_entry_type scanEnt = table_reg[scanIdx_reg];
   sta_pkg::sta_entry_type agedEnt;
   always_comb begin
      agedEnt = scanEnt;
      if (scanEnt.valid && scanEnt.aged
         && scanEnt.entryType == sta_pkg::TYPE_AGING)
         agedEnt = '0;
      else if (scanEnt.valid && !scanEnt.aged)
         agedEnt.aged = 1'b1;
   end

   // processor entry image from the key and access registers
   sta_pkg::sta_entry_type cpuEnt;
   always_comb begin
      cpuEnt.valid = access_reg[sta_pkg::ACC_VALID_BIT];
      cpuEnt.stationAddr = {keyHigh_reg[15:0], keyLow_reg};
      cpuEnt.vlan = keyHigh_reg[28:16];
      cpuEnt.destPtr = access_reg[sta_pkg::ACC_DEST_LSB +: 6];
      cpuEnt.entryType = access_reg[sta_pkg::ACC_TYPE_LSB +: 2];
      cpuEnt.aged = access_reg[sta_pkg::ACC_AGED_BIT];
      cpuEnt.copyFlag = access_reg[sta_pkg::ACC_COPY_BIT];
      cpuEnt.dropFlag = access_reg[sta_pkg::ACC_DROP_BIT];
      cpuEnt.bypassFlag = access_reg[sta_pkg::ACC_BYPASS_BIT];
   end
   wire sta_pkg::sta_entry_type rdEnt = table_reg[cpuIdx];

   ////////////////////////////////////////////////////////////////////////
   // periodic scan: microsecond tick, then count period in ticks
   wire logic tick = tickCnt_reg == 32'(PERIOD_TICKS - 1);
   wire logic periodDone = period_reg != 32'h0
      && tick && periodCnt_reg + 32'h1 >= period_reg;
   wire logic wrAccess = regWrite && regAddr == sta_pkg::REG_ACCESS
      && !cmdBusy;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tickCnt_reg <= 32'h0;
         periodCnt_reg <= 32'h0;
         scanPend_reg <= 1'b0;
      end else begin
         tickCnt_reg <= tick ? 32'h0 : tickCnt_reg + 32'h1;
         if (periodDone)
            periodCnt_reg <= 32'h0;
         else if (tick)
            periodCnt_reg <= periodCnt_reg + 32'h1;
         if (periodDone)
            scanPend_reg <= 1'b1;
         else if (state_reg == ST_IDLE)
            scanPend_reg <= scanPend_reg && reqValid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequencer: frame requests first, then scans, then commands
   assign reqReady = state_reg == ST_IDLE;
   wire logic startScan = !reqValid && (scanPend_reg
      || cmdField == sta_pkg::CMD_AGE);
   wire logic startCpu = !reqValid && !scanPend_reg
      && (cmdField == sta_pkg::CMD_READ
      || cmdField == sta_pkg::CMD_WRITE);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         scanIdx_reg <= 12'h000;
         req_reg <= '0;
         respValid <= 1'b0;
         respData <= '0;
      end else begin
         respValid <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               if (reqValid) begin
                  req_reg <= reqData;
                  state_reg <= ST_LOOK;
               end else if (startScan) begin
                  scanIdx_reg <= 12'h000;
                  state_reg <= ST_SCAN;
               end else if (startCpu) begin
                  state_reg <= ST_CPU;
               end
            end
            ST_LOOK: begin
               respValid <= 1'b1;
               respData.srcHit <= srcHit;
               respData.srcDrop <= srcHit && srcEnt.dropFlag;
               respData.dstHit <= dstHit;
               respData.dstPtr <= dstEnt.destPtr;
               respData.copyCpu <= (srcHit && srcEnt.copyFlag)
                  || (dstHit && dstEnt.copyFlag);
               respData.vlanBypass <= dstHit && dstEnt.bypassFlag;
               state_reg <= ST_ANSWER;
            end
            ST_ANSWER: state_reg <= ST_IDLE;
            ST_SCAN: begin
               scanIdx_reg <= scanIdx_reg + 12'h001;
               if (scanIdx_reg == 12'hfff)
                  state_reg <= ST_IDLE;
            end
            ST_CPU: state_reg <= ST_IDLE;
         endcase
      end
   end

   // table storage writes; stored without reset like a ram
   always_ff @(posedge core_clk) begin
      if (state_reg == ST_LOOK && learnEn) begin
         if (srcHit && srcEnt.entryType inside {sta_pkg::TYPE_AGING,
            sta_pkg::TYPE_LOCKED})
            table_reg[{srcRow, srcB}] <= hitEnt;
         else if (doLearn && |freeMask)
            table_reg[{srcRow, freeB}] <= learnEnt;
      end else if (state_reg == ST_SCAN) begin
         table_reg[scanIdx_reg] <= agedEnt;
      end else if (state_reg == ST_CPU
         && cmdField == sta_pkg::CMD_WRITE) begin
         table_reg[cpuIdx] <= cpuEnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-port learned counts; freed entries are not tracked back
   wire logic learnedNow = state_reg == ST_LOOK && doLearn && |freeMask;
   always_ff @(posedge core_clk) begin
      for (int p = 0; p < sta_pkg::PORTS; p++) begin
         if (sys_rst) begin
            learned_reg[p] <= '0;
            limit_reg[p] <= sta_pkg::LIMIT_RESET;
         end else begin
            if (learnedNow && 32'(logical_ingress_port) == p)
               learned_reg[p] <= learned_reg[p] + 12'h001;
            if (regWrite && regAddr == sta_pkg::REG_LIMIT
               && 32'(limitSel_reg) == p)
               limit_reg[p] <= regWrData[11:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file
   // a periodic scan must not retire a read or write command written while it ran; an age command written then is retired
   wire logic cmdDone = state_reg == ST_CPU
      || (state_reg == ST_SCAN && scanIdx_reg == 12'hfff
      && cmdField == sta_pkg::CMD_AGE);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         keyLow_reg <= 32'h0;
         keyHigh_reg <= 32'h0;
         index_reg <= 32'h0;
         options_reg <= 32'h0;
         period_reg <= sta_pkg::PERIOD_RESET;
         defaults_reg <= sta_pkg::DEFAULTS_RESET;
         access_reg <= 32'h0;
         discard_reg <= 32'h0;
         limitSel_reg <= 4'h0;
      end else begin
         if (regWrite) begin
            unique case (regAddr)
               sta_pkg::REG_KEY_LOW: keyLow_reg <= regWrData;
               sta_pkg::REG_KEY_HIGH: keyHigh_reg <= regWrData;
               sta_pkg::REG_INDEX: index_reg <= regWrData;
               sta_pkg::REG_OPTIONS: options_reg <= regWrData;
               sta_pkg::REG_PERIOD: period_reg <= regWrData;
               sta_pkg::REG_DEFAULTS: defaults_reg <= regWrData;
               sta_pkg::REG_LIMIT_SEL: limitSel_reg <= regWrData[3:0];
               default: ;
            endcase
         end
         if (wrAccess)
            access_reg <= regWrData;
         else if (cmdDone) begin
            access_reg[2:0] <= sta_pkg::CMD_IDLE;
            if (cmdField == sta_pkg::CMD_READ) begin
               access_reg[sta_pkg::ACC_VALID_BIT] <= rdEnt.valid;
               access_reg[sta_pkg::ACC_DEST_LSB +: 6] <= rdEnt.destPtr;
               access_reg[sta_pkg::ACC_TYPE_LSB +: 2] <= rdEnt.entryType;
               access_reg[sta_pkg::ACC_AGED_BIT] <= rdEnt.aged;
               access_reg[sta_pkg::ACC_COPY_BIT] <= rdEnt.copyFlag;
               access_reg[sta_pkg::ACC_DROP_BIT] <= rdEnt.dropFlag;
               access_reg[sta_pkg::ACC_BYPASS_BIT] <= rdEnt.bypassFlag;
            end
         end
         if (cmdDone && cmdField == sta_pkg::CMD_READ) begin
            keyLow_reg <= rdEnt.stationAddr[31:0];
            keyHigh_reg <= {3'h0, rdEnt.vlan, rdEnt.stationAddr[47:32]};
         end
         // saturates so software never sees a wrap
         if (state_reg == ST_LOOK && noRoom && discard_reg != 32'hffffffff)
            discard_reg <= discard_reg + 32'h1;
      end
   end

   wire logic portSelOk = 32'(limitSel_reg) < sta_pkg::PORTS;
   always_comb begin
      unique case (regAddr)
         sta_pkg::REG_KEY_LOW: regRdData_next = keyLow_reg;
         sta_pkg::REG_KEY_HIGH: regRdData_next = keyHigh_reg;
         sta_pkg::REG_INDEX: regRdData_next = index_reg;
         sta_pkg::REG_ACCESS: regRdData_next = access_reg;
         sta_pkg::REG_OPTIONS: regRdData_next = options_reg;
         sta_pkg::REG_PERIOD: regRdData_next = period_reg;
         sta_pkg::REG_DEFAULTS: regRdData_next = defaults_reg;
         sta_pkg::REG_DISCARD: regRdData_next = discard_reg;
         sta_pkg::REG_LIMIT_SEL: regRdData_next = {28'h0, limitSel_reg};
         sta_pkg::REG_LIMIT:
            regRdData_next = portSelOk ? {20'h0, limit_reg[limitSel_reg]}
               : 32'h0;
         sta_pkg::REG_LEARN_CNT:
            regRdData_next = portSelOk ? {20'h0, learned_reg[limitSel_reg]}
               : 32'h0;
         default: regRdData_next = 32'h0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst)
         regRdData <= 32'h0;
      else if (regRead)
         regRdData <= regRdData_next;
      else
         regRdData <= 32'h0;
   end
endmodule
`default_nettype wire

// ### sim/sta_station_table_properties.sv
// Purpose: port properties of the station table
// Assumes: one clock domain, synchronous active high reset
// Notes: sees the top module ports only and is bound into every instance
`timescale 1ns/100ps
`default_nettype none
module sta_station_table_properties #(
   parameter int PERIOD_TICKS = sta_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] regAddr,
   input wire logic regRead,
   input wire logic [31:0] regRdData,
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic respValid,
   input wire sta_pkg::sta_resp_type respData
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_take;
      reqValid && reqReady;
   endsequence
   sequence s_busy;
      !reqReady [*2] ##1 reqReady;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_read_window: assert property (
      !$past(regRead) |-> regRdData == 32'h0) else $error("stray read data");
   a_unmapped_zero: assert property (
      $past(regRead) && $past(regAddr) > 4'ha |-> regRdData == 32'h0)
      else $error("unmapped read not zero");
   a_busy_after_take: assert property (
      s_take |=> s_busy) else $error("ready wrong after take");
   a_answer_time: assert property (
      s_take |-> ##2 respValid) else $error("answer late");
   a_answer_cause: assert property (
      respValid |-> $past(reqValid && reqReady, 2))
      else $error("answer without request");
   a_answer_pulse: assert property (
      respValid |=> !respValid) else $error("answer not a pulse");
   a_answer_hold: assert property (
      !respValid |-> $stable(respData)) else $error("answer data moved");
   a_drop_on_hit: assert property (
      respValid && respData.srcDrop |-> respData.srcHit)
      else $error("drop without source hit");
   a_bypass_dest: assert property (
      respValid && respData.vlanBypass |-> respData.dstHit)
      else $error("bypass without destination hit");
endmodule

bind sta_station_table sta_station_table_properties #(
   .PERIOD_TICKS(PERIOD_TICKS)
) i_props (
   .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
   .regRead(regRead), .regRdData(regRdData), .reqValid(reqValid),
   .reqReady(reqReady), .respValid(respValid), .respData(respData)
);
`default_nettype wire

// ### sim/sta_frame_src.sv
// Purpose: model of the frame analysis path feeding lookups
// Assumes: one request in flight, taken at an edge with reqReady high
// Notes: payload is inverted once taken so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
module sta_frame_src (
   input wire logic core_clk,
   input wire logic reqReady,
   input wire logic respValid,
   input wire sta_pkg::sta_resp_type respData,
   output logic reqValid,
   output sta_pkg::sta_req_type reqData
);
   initial begin
      reqValid = 1'b0;
      reqData = '0;
   end
   task automatic send(input logic [47:0] sa, input logic [47:0] da,
         input logic [3:0] pt, output sta_pkg::sta_resp_type rs,
         output logic ok);
      logic got;
      ok = 1'b0;
      got = 1'b0;
      @(posedge core_clk);
      reqValid <= 1'b1;
      reqData <= {sa, da, 12'h001, pt};
      // long bound: a running age scan holds off lookups for a whole pass
      for (int n = 0; n < 5000 && !ok; n++) begin
         #1 ok = reqReady;
         @(posedge core_clk);
      end
      reqValid <= 1'b0;
      reqData <= ~{sa, da, 12'h001, pt};
      for (int n = 0; n < 9 && !got; n++) begin
         @(posedge core_clk);
         #1 got = respValid;
      end
      rs = respData;
      ok = ok & got;
   endtask
endmodule
`default_nettype wire

// ### sim/sta_station_table_tb.sv
// Purpose: self-checking bench for the station table
// Assumes: every entry is cleared by processor writes before frames
// Notes: scan tick cut to two cycles so periodic scans fit the run
`timescale 1ns/100ps
`default_nettype none
module sta_station_table_tb;
   logic core_clk;
   logic sys_rst;
   logic [3:0] regAddr;
   logic [31:0] regWrData;
   logic regWrite;
   logic regRead;
   logic [31:0] regRdData;
   logic reqValid;
   sta_pkg::sta_req_type reqData;
   logic reqReady;
   logic respValid;
   sta_pkg::sta_resp_type respData;
   sta_pkg::sta_resp_type r;
   logic [31:0] v;
   logic [11:0] ix;
   logic [47:0] fill [4] = '{48'ha, 48'h40b, 48'h808, 48'hc09};
   int nFail = 0;
   int checked = 0;

   sta_station_table #(.PERIOD_TICKS(2)) i_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .reqValid(reqValid), .reqData(reqData),
      .reqReady(reqReady), .respValid(respValid), .respData(respData)
   );
   sta_frame_src i_src (
      .core_clk(core_clk), .reqReady(reqReady), .respValid(respValid),
      .respData(respData), .reqValid(reqValid), .reqData(reqData)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, nFail);
      if (nFail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checked++;
      if (g !== e) begin
         nFail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 v = regRdData;
   endtask
   // polls until the command field drops back to idle
   task automatic cmd(input logic [31:0] a);
      v = 32'h7;
      wr(sta_pkg::REG_ACCESS, a);
      for (int n = 0; n < 6000 && v[2:0] !== sta_pkg::CMD_IDLE; n++) rd(4'h3);
      chk("command", 32'(sta_pkg::CMD_IDLE), 32'(v[2:0]));
      if (v[2:0] !== sta_pkg::CMD_IDLE) end_sim();
   endtask
   function automatic logic [31:0] acc(input logic vd, input logic [1:0] ty,
         input logic ag, input logic [5:0] dp, input logic [2:0] cm);
      return {10'h0, dp, 5'h0, vd, 3'h0, ag, ty, 1'b0, cm};
   endfunction
   // own copy of the xor fold; a mismatch here shows up as wrong rows
   function automatic logic [9:0] rowOf(input logic [47:0] a);
      logic [59:0] k;
      k = {a, 12'h001};
      rowOf = '0;
      for (int i = 0; i < 6; i++) rowOf ^= k[i*10 +: 10];
   endfunction
   task automatic ent(input logic [47:0] a, input logic [1:0] b,
         input logic [31:0] ac);
      wr(sta_pkg::REG_KEY_LOW, a[31:0]);
      wr(sta_pkg::REG_KEY_HIGH, {16'h0001, a[47:32]});
      wr(sta_pkg::REG_INDEX, {14'h0, b, 6'h0, rowOf(a)});
      cmd(ac);
   endtask
   task automatic fr(input logic [47:0] sa, input logic [47:0] da,
         input logic [3:0] pt);
      logic ok;
      i_src.send(sa, da, pt, r, ok);
      chk("answer", 32'h1, 32'(ok));
      if (ok !== 1'b1) end_sim();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      sys_rst = 1'b1;
      regAddr = 4'h0;
      regWrData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(sta_pkg::REG_DEFAULTS);
      chk("defaults", sta_pkg::DEFAULTS_RESET, v);
      rd(4'hf);
      chk("unmapped", 32'h0, v);
      wr(sta_pkg::REG_LIMIT_SEL, 32'h6);
      rd(sta_pkg::REG_LIMIT);
      chk("limit", 32'(sta_pkg::LIMIT_RESET), v);
      for (int i = 0; i < sta_pkg::ENTRIES; i++) begin
         ix = 12'(i);
         wr(sta_pkg::REG_INDEX, {14'h0, ix[11:10], 6'h0, ix[9:0]});
         cmd(acc(1'b0, 2'h0, 1'b0, 6'h0, sta_pkg::CMD_WRITE));
      end
      wr(sta_pkg::REG_DEFAULTS, 32'hb);
      fr(48'h1, 48'h0, 4'h3);
      chk("src hit", 32'h0, 32'(r.srcHit));
      fr(48'h1, 48'h0, 4'h3);
      chk("src hit", 32'h1, 32'(r.srcHit));
      fr(48'h2, 48'h1, 4'h4);
      chk("dst ptr", 32'h3, 32'(r.dstPtr));
      chk("copy", 32'h1, 32'(r.copyCpu));
      chk("bypass", 32'h1, 32'(r.vlanBypass));
      fr(48'h1, 48'h0, 4'h5);
      fr(48'h2, 48'h1, 4'h4);
      chk("moved ptr", 32'h5, 32'(r.dstPtr));
      chk("src drop", 32'h0, 32'(r.srcDrop));
      wr(sta_pkg::REG_DEFAULTS, 32'h5);
      fr(48'h5, 48'h0, 4'h1);
      fr(48'h5, 48'h0, 4'h1);
      chk("src drop", 32'h1, 32'(r.srcDrop));
      fr(48'h2, 48'h5, 4'h4);
      chk("dst hit", 32'h1, 32'(r.dstHit));
      ent(48'h3, 2'h0, acc(1'b1, 2'h1, 1'b1, 6'h7, sta_pkg::CMD_WRITE));
      ent(48'h4, 2'h1, acc(1'b1, 2'h2, 1'b1, 6'h9, sta_pkg::CMD_WRITE));
      fr(48'h3, 48'h0, 4'h2);
      fr(48'h4, 48'h0, 4'h2);
      ent(48'h3, 2'h0, acc(1'b0, 2'h0, 1'b0, 6'h0, sta_pkg::CMD_READ));
      chk("locked", acc(1'b1, 2'h1, 1'b0, 6'h7, 3'h0), v);
      ent(48'h4, 2'h1, acc(1'b0, 2'h0, 1'b0, 6'h0, sta_pkg::CMD_READ));
      chk("mcast", acc(1'b1, 2'h2, 1'b1, 6'h9, 3'h0), v);
      for (int k = 0; k < 4; k++)
         ent(fill[k], 2'(k), acc(1'b1, 2'h1, 1'b0, 6'h0, 3'h5));
      fr(48'h100e, 48'h0, 4'h1);
      wr(sta_pkg::REG_LIMIT, 32'h1);
      fr(48'h6, 48'h0, 4'h6);
      fr(48'h7, 48'h0, 4'h6);
      fr(48'h2, 48'h6, 4'h4);
      chk("under limit", 32'h1, 32'(r.dstHit));
      fr(48'h2, 48'h7, 4'h4);
      chk("over limit", 32'h0, 32'(r.dstHit));
      rd(sta_pkg::REG_LEARN_CNT);
      chk("learned", 32'h1, v);
      rd(sta_pkg::REG_DISCARD);
      chk("discards", 32'h1, v);
      wr(sta_pkg::REG_DEFAULTS, 32'h0);
      fr(48'h8, 48'h0, 4'h1);
      fr(48'h2, 48'h8, 4'h4);
      chk("no learn", 32'h0, 32'(r.dstHit));
      wr(sta_pkg::REG_DEFAULTS, 32'h1);
      cmd(acc(1'b0, 2'h0, 1'b0, 6'h0, sta_pkg::CMD_AGE));
      ent(48'h3, 2'h0, acc(1'b0, 2'h0, 1'b0, 6'h0, sta_pkg::CMD_READ));
      chk("aged", acc(1'b1, 2'h1, 1'b1, 6'h7, 3'h0), v);
      fr(48'h2, 48'h1, 4'h4);
      chk("kept", 32'h1, 32'(r.dstHit));
      cmd(acc(1'b0, 2'h0, 1'b0, 6'h0, sta_pkg::CMD_AGE));
      fr(48'h2, 48'h1, 4'h4);
      chk("removed", 32'h0, 32'(r.dstHit));
      fr(48'h2, 48'h3, 4'h4);
      chk("locked kept", 32'h1, 32'(r.dstHit));
      fr(48'h9, 48'h0, 4'h1);
      wr(sta_pkg::REG_PERIOD, 32'h1);
      repeat (10000) @(posedge core_clk);
      wr(sta_pkg::REG_PERIOD, 32'h0);
      fr(48'h2, 48'h9, 4'h4);
      chk("periodic", 32'h0, 32'(r.dstHit));
      end_sim();
   end
endmodule
`default_nettype wire
